// File: rtl/usr_defines.vh
// Purpose: Constants for the serial channel status/interrupt/flow register block
// Assumes: Avalon-MM word addressing, 8-bit data in low bits of 32-bit word
// Notes: Offsets are word indices on the register bus
`ifndef USR_DEFINES_VH
`define USR_DEFINES_VH
// Register word offsets
`define USR_OFF_MODEM_LINE_STATUS 3'h0
`define USR_OFF_INTERRUPT_ENABLE 3'h1
`define USR_OFF_INTERRUPT_SOURCE_ID 3'h2
`define USR_OFF_ENHANCED_FEATURE 3'h3
`define USR_OFF_BAUD_DIVISOR_LOW 3'h4
`define USR_OFF_BAUD_DIVISOR_HIGH 3'h5
`define USR_OFF_FLOW_LEVELS 3'h6
`define USR_OFF_LINE_CONTROL 3'h7
// Field positions
`define USR_EFR_WREN 4
`define USR_EFR_SPECIAL 5
`define USR_EFR_AUTO_RTS 6
`define USR_EFR_AUTO_CTS 7
`define USR_MCR_LOOP 4
`define USR_MCR_LEVELS_EN 6
`define USR_IER_THR 1
`define USR_IER_SLEEP 4
// Reset values
`define USR_RST_BYTE 8'h00
`define USR_RST_DIVISOR 16'h0001
// Identification codes, bits 5:0
`define USR_ID_NONE 6'h01
`define USR_ID_LINE 6'h06
`define USR_ID_TIMEOUT 6'h0C
`define USR_ID_RXDATA 6'h04
`define USR_ID_TXEMPTY 6'h02
`define USR_ID_MODEM 6'h00
`define USR_ID_XOFF 6'h10
`define USR_ID_FLOWCHG 6'h20
// Threshold granularity shift (steps of four)
`define USR_LEVEL_SHIFT 2
`endif

// File: rtl/usr_int_prio.v
// Purpose: Priority encoder of pending interrupt sources into an id code
// Assumes: Sources arrive already gated by their enables
// Notes: Purely combinational
`include "usr_defines.vh"
module usr_int_prio (
  input wire line_err,
  input wire rx_timeout,
  input wire rx_data,
  input wire tx_empty,
  input wire modem,
  input wire xoff,
  input wire flow_chg,
  output reg pending,
  output reg [5:0] id_code
);
  // Highest pending source wins
  always @* begin
    pending = 1'b1;
    if (line_err) begin
      id_code = `USR_ID_LINE;
    end else if (rx_timeout) begin
      id_code = `USR_ID_TIMEOUT;
    end else if (rx_data) begin
      id_code = `USR_ID_RXDATA;
    end else if (tx_empty) begin
      id_code = `USR_ID_TXEMPTY;
    end else if (modem) begin
      id_code = `USR_ID_MODEM;
    end else if (xoff) begin
      id_code = `USR_ID_XOFF;
    end else if (flow_chg) begin
      id_code = `USR_ID_FLOWCHG;
    end else begin
      id_code = `USR_ID_NONE;
      pending = 1'b0;
    end
  end
endmodule // usr_int_prio

// File: rtl/usr_regs.v
// Purpose: Per-channel modem status, interrupt, flow control and divisor registers
// Assumes: One clock, synchronous active-high reset, inputs synchronous to clk
// Notes: Registers reached over Avalon-MM; one wait state on every access
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`include "usr_defines.vh"
module usr_regs #(
  parameter FIFO_CNT_W = 7
) (
  input wire clk,
  input wire reset,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire cd_n,
  output reg rts_n,
  output wire dtr_n,
  output wire int_out,
  input wire line_err_evt,
  input wire rx_timeout_evt,
  input wire rx_data_avail,
  input wire tx_below_level,
  input wire tx_serial_in,
  input wire rx_pin,
  output wire rx_serial_out,
  input wire rx_char_valid,
  input wire [7:0] rx_char,
  input wire [7:0] xoff2_char,
  input wire [FIFO_CNT_W-1:0] rx_fifo_level,
  input wire fifo_enable,
  input wire [1:0] fifo_setup_in,
  output wire [1:0] fifo_setup_bits,
  output wire tx_halt,
  output wire [15:0] baud_divisor,
  output wire sleep_enable,
  output wire loopback_tx
);
  // Divisor after reset, split into its two latches
  localparam [15:0] RST_DIV = `USR_RST_DIVISOR;
  reg [7:0] interrupt_enable_reg;
  reg [7:0] enhanced_feature_control_reg;
  reg [7:0] baud_divisor_low_reg;
  reg [7:0] baud_divisor_high_reg;
  reg [7:0] flow_halt_restore_levels_reg;
  reg [7:0] modem_line_control_reg;
  reg [1:0] fifo_setup_reg;
  reg [3:0] delta_reg;
  reg [3:0] prev_mod_reg;
  reg thr_int_reg;
  reg xoff_flag_reg;
  reg flow_chg_reg;
  reg prev_cts_reg;
  reg prev_rts_reg;
  reg ack_reg;
  reg prev_tx_below_reg;
  wire access;
  wire wr_stb;
  wire rd_cap;
  wire status_clr;
  wire id_clr;
  wire tx_rise;
  wire loop;
  wire [3:0] mod_now;
  wire [7:0] status_byte;
  wire pending;
  wire [5:0] id_code;
  wire [7:0] id_byte;
  wire [7:0] wdat;
  wire efr_wren;
  wire [FIFO_CNT_W-1:0] halt_level;
  wire [FIFO_CNT_W-1:0] restore_level;
  wire cts_active;
  wire src_line;
  wire src_tmo;
  wire src_rx;
  wire src_tx;
  wire src_mod;
  wire src_xoff;
  wire src_flow;

  // Threshold nibble to character count
  function [FIFO_CNT_W-1:0] level_of;
    input [3:0] nib;
    begin
      level_of = {{(FIFO_CNT_W-4){1'b0}}, nib} << `USR_LEVEL_SHIFT;
    end
  endfunction

  // Service read of the id register while the given code is the one shown
  function serviced;
    input clr;
    input [5:0] shown;
    input [5:0] code;
    begin
      serviced = clr & (shown == code);
    end
  endfunction

  // Bus handshake: one wait cycle, answer on second edge
  assign access = (avs_read | avs_write) & ~ack_reg;
  assign avs_waitrequest = access;
  assign wr_stb = avs_write & ack_reg;
  // Clears act on the edge that captures read data, so no event goes unseen
  assign rd_cap = avs_read & ~ack_reg;
  assign status_clr = rd_cap & (avs_address == `USR_OFF_MODEM_LINE_STATUS);
  assign id_clr = rd_cap & (avs_address == `USR_OFF_INTERRUPT_SOURCE_ID);
  assign wdat = avs_writedata[7:0];
  assign efr_wren = enhanced_feature_control_reg[`USR_EFR_WREN];

  always @(posedge clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end

  // Modem inputs or loopback sources, active-high: cts, dsr, ri, cd
  assign loop = modem_line_control_reg[`USR_MCR_LOOP];
  assign mod_now = loop ? {modem_line_control_reg[3], modem_line_control_reg[2],
                           modem_line_control_reg[0], modem_line_control_reg[1]}
                        : {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
  assign status_byte = {mod_now[3], mod_now[2], mod_now[1], mod_now[0], delta_reg};

  // Change detection; a new change wins over a clearing read
  always @(posedge clk) begin
    if (reset) begin
      prev_mod_reg <= 4'h0;
      delta_reg <= 4'h0;
    end else begin
      prev_mod_reg <= mod_now;
      if (status_clr) begin
        delta_reg[0] <= mod_now[0] ^ prev_mod_reg[0];
        delta_reg[1] <= mod_now[1] ^ prev_mod_reg[1];
        delta_reg[2] <= ~mod_now[2] & prev_mod_reg[2];
        delta_reg[3] <= mod_now[3] ^ prev_mod_reg[3];
      end else begin
        delta_reg[0] <= delta_reg[0] | (mod_now[0] ^ prev_mod_reg[0]);
        delta_reg[1] <= delta_reg[1] | (mod_now[1] ^ prev_mod_reg[1]);
        // Pin low-to-high is active bit falling
        delta_reg[2] <= delta_reg[2] | (~mod_now[2] & prev_mod_reg[2]);
        delta_reg[3] <= delta_reg[3] | (mod_now[3] ^ prev_mod_reg[3]);
      end
    end
  end

  // Register writes with their write-enable gates
  always @(posedge clk) begin
    if (reset) begin
      interrupt_enable_reg <= `USR_RST_BYTE;
      enhanced_feature_control_reg <= `USR_RST_BYTE;
      baud_divisor_low_reg <= RST_DIV[7:0];
      baud_divisor_high_reg <= RST_DIV[15:8];
      flow_halt_restore_levels_reg <= `USR_RST_BYTE;
      modem_line_control_reg <= `USR_RST_BYTE;
      fifo_setup_reg <= 2'h0;
    end else if (wr_stb) begin
      case (avs_address)
        `USR_OFF_INTERRUPT_ENABLE: begin
          interrupt_enable_reg[3:0] <= wdat[3:0];
          if (efr_wren) begin
            interrupt_enable_reg[7:4] <= wdat[7:4];
          end
        end
        `USR_OFF_ENHANCED_FEATURE: begin
          enhanced_feature_control_reg <= wdat;
          if (efr_wren) begin
            fifo_setup_reg <= fifo_setup_in;
          end
        end
        `USR_OFF_BAUD_DIVISOR_LOW: begin
          if (!interrupt_enable_reg[`USR_IER_SLEEP]) begin
            baud_divisor_low_reg <= wdat;
          end
        end
        `USR_OFF_BAUD_DIVISOR_HIGH: begin
          if (!interrupt_enable_reg[`USR_IER_SLEEP]) begin
            baud_divisor_high_reg <= wdat;
          end
        end
        `USR_OFF_FLOW_LEVELS: begin
          if (efr_wren && modem_line_control_reg[`USR_MCR_LEVELS_EN]) begin
            flow_halt_restore_levels_reg <= wdat;
          end
        end
        `USR_OFF_LINE_CONTROL: begin
          modem_line_control_reg[4:0] <= wdat[4:0];
          if (efr_wren) begin
            modem_line_control_reg[7:5] <= wdat[7:5];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Transmit-empty interrupt: raised when the level falls below threshold or
  // when its enable is set again; dropped once the level recovers or on service
  assign tx_rise = tx_below_level & ~prev_tx_below_reg;
  always @(posedge clk) begin
    if (reset) begin
      prev_tx_below_reg <= 1'b1; // No false rise out of reset
      thr_int_reg <= 1'b0;
    end else begin
      prev_tx_below_reg <= tx_below_level;
      if (tx_rise || (wr_stb && avs_address == `USR_OFF_INTERRUPT_ENABLE &&
          wdat[`USR_IER_THR] && !interrupt_enable_reg[`USR_IER_THR])) begin
        thr_int_reg <= tx_below_level;
      end else if (!tx_below_level) begin
        thr_int_reg <= 1'b0;
      end else if (serviced(id_clr, id_code, `USR_ID_TXEMPTY)) begin
        thr_int_reg <= 1'b0;
      end
    end
  end

  // Special character flag: set wins over clearing read
  always @(posedge clk) begin
    if (reset) begin
      xoff_flag_reg <= 1'b0;
    end else if (enhanced_feature_control_reg[`USR_EFR_SPECIAL] && rx_char_valid &&
                 rx_char == xoff2_char) begin
      xoff_flag_reg <= 1'b1;
    end else if (serviced(id_clr, id_code, `USR_ID_XOFF)) begin
      xoff_flag_reg <= 1'b0;
    end
  end

  // CTS/RTS active-to-inactive detection
  assign cts_active = mod_now[0];
  always @(posedge clk) begin
    if (reset) begin
      prev_cts_reg <= 1'b0;
      prev_rts_reg <= 1'b0;
      flow_chg_reg <= 1'b0;
    end else begin
      prev_cts_reg <= cts_active;
      prev_rts_reg <= ~rts_n;
      if ((prev_cts_reg && !cts_active) || (prev_rts_reg && rts_n)) begin
        flow_chg_reg <= 1'b1;
      end else if (serviced(id_clr, id_code, `USR_ID_FLOWCHG)) begin
        flow_chg_reg <= 1'b0;
      end
    end
  end

  // Automatic RTS by receive FIFO level, else control bit 1
  assign halt_level = level_of(flow_halt_restore_levels_reg[3:0]);
  assign restore_level = level_of(flow_halt_restore_levels_reg[7:4]);
  always @(posedge clk) begin
    if (reset) begin
      rts_n <= 1'b1;
    end else if (enhanced_feature_control_reg[`USR_EFR_AUTO_RTS]) begin
      if (rx_fifo_level >= halt_level) begin
        rts_n <= 1'b1;
      end else if (rx_fifo_level <= restore_level) begin
        rts_n <= 1'b0;
      end
    end else begin
      rts_n <= ~modem_line_control_reg[1];
    end
  end

  assign tx_halt = enhanced_feature_control_reg[`USR_EFR_AUTO_CTS] & ~cts_active;

  // Gated interrupt sources
  assign src_line = interrupt_enable_reg[2] & line_err_evt;
  assign src_tmo = interrupt_enable_reg[0] & rx_timeout_evt;
  assign src_rx = interrupt_enable_reg[0] & rx_data_avail;
  assign src_tx = interrupt_enable_reg[1] & thr_int_reg;
  assign src_mod = interrupt_enable_reg[3] & (|delta_reg);
  assign src_xoff = interrupt_enable_reg[5] & xoff_flag_reg;
  assign src_flow = (interrupt_enable_reg[6] | interrupt_enable_reg[7]) & flow_chg_reg;

  usr_int_prio u_prio (
    .line_err(src_line),
    .rx_timeout(src_tmo),
    .rx_data(src_rx),
    .tx_empty(src_tx),
    .modem(src_mod),
    .xoff(src_xoff),
    .flow_chg(src_flow),
    .pending(pending),
    .id_code(id_code)
  );

  assign int_out = pending;
  assign id_byte = {fifo_enable, fifo_enable, id_code};

  // Read data mux, registered
  always @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_cap) begin
      case (avs_address)
        `USR_OFF_MODEM_LINE_STATUS: avs_readdata <= {24'h000000, status_byte};
        `USR_OFF_INTERRUPT_ENABLE: avs_readdata <= {24'h000000, interrupt_enable_reg};
        `USR_OFF_INTERRUPT_SOURCE_ID: avs_readdata <= {24'h000000, id_byte};
        `USR_OFF_ENHANCED_FEATURE: avs_readdata <= {24'h000000, enhanced_feature_control_reg};
        `USR_OFF_BAUD_DIVISOR_LOW: avs_readdata <= {24'h000000, baud_divisor_low_reg};
        `USR_OFF_BAUD_DIVISOR_HIGH: avs_readdata <= {24'h000000, baud_divisor_high_reg};
        `USR_OFF_FLOW_LEVELS: avs_readdata <= {24'h000000, flow_halt_restore_levels_reg};
        `USR_OFF_LINE_CONTROL: avs_readdata <= {24'h000000, modem_line_control_reg};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  assign baud_divisor = {baud_divisor_high_reg, baud_divisor_low_reg};
  assign sleep_enable = interrupt_enable_reg[`USR_IER_SLEEP];
  assign dtr_n = ~modem_line_control_reg[0];
  assign fifo_setup_bits = fifo_setup_reg;
  // Loopback: transmit line feeds receiver, line held idle high
  assign rx_serial_out = loop ? tx_serial_in : rx_pin;
  assign loopback_tx = loop ? 1'b1 : tx_serial_in;
endmodule // usr_regs

// File: dv/usr_regs_sva.sv
// Purpose: Port-level timing and side-effect checks for usr_regs
// Assumes: One wait state per bus access, one clock domain
// Notes: Attached by the bind at the foot of this file
module usr_regs_sva #(
  parameter FIFO_CNT_W = 7
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic cts_n,
  input wire logic tx_halt,
  input wire logic rx_pin,
  input wire logic tx_serial_in,
  input wire logic rx_serial_out,
  input wire logic loopback_tx,
  input wire logic [15:0] baud_divisor,
  input wire logic sleep_enable,
  input wire logic [1:0] fifo_setup_bits
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req_q, wr_q, rd_q, rst_q;
  logic [2:0] adr_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Previous-cycle view of the bus
  always @(posedge clk) begin
    req_q <= avs_read || avs_write;
    wr_q <= avs_write && !avs_waitrequest;
    rd_q <= avs_read;
    adr_q <= avs_address;
    rst_q <= reset;
  end
  a_wait_first: assert property ((avs_read || avs_write) && !req_q |-> avs_waitrequest)
    else $error("no wait state on new request");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !(avs_read || avs_write) || !avs_waitrequest)
    else $error("more than one wait state");
  a_rdata_hold: assert property (!rd_q && !rst_q |-> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_rdata_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_halt_cts: assert property (tx_halt |-> cts_n)
    else $error("transmit halted with clear to send active");
  a_loop_path: assert property (rx_serial_out != rx_pin
    |-> rx_serial_out == tx_serial_in && loopback_tx)
    else $error("receive path neither line nor loop");
  a_sleep_div: assert property (sleep_enable |=> $stable(baud_divisor))
    else $error("divisor written while sleeping");
  a_div_write: assert property ($changed(baud_divisor) && !rst_q
    |-> wr_q && (adr_q == 3'h4 || adr_q == 3'h5))
    else $error("divisor changed without latch write");
  a_sleep_write: assert property ($changed(sleep_enable) && !rst_q
    |-> wr_q && adr_q == 3'h1)
    else $error("sleep changed without enable write");
  a_setup_write: assert property ($changed(fifo_setup_bits) && !rst_q
    |-> wr_q && adr_q == 3'h3)
    else $error("fifo setup changed without feature write");
endmodule // usr_regs_sva
bind usr_regs usr_regs_sva #(.FIFO_CNT_W(FIFO_CNT_W)) u_sva (.clk(clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cts_n(cts_n),
  .tx_halt(tx_halt), .rx_pin(rx_pin), .tx_serial_in(tx_serial_in),
  .rx_serial_out(rx_serial_out), .loopback_tx(loopback_tx), .baud_divisor(baud_divisor),
  .sleep_enable(sleep_enable), .fifo_setup_bits(fifo_setup_bits));

// File: dv/usr_modem_model.sv
// Purpose: Modem side model driving the active-low status lines
// Assumes: Lines change on the system clock
// Notes: Receive line idles at mark
module usr_modem_model (
  input wire logic clk,
  input wire logic [3:0] lines,
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic cd_n,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Asserted lines are driven low
  always @(posedge clk) {cd_n, ri_n, dsr_n, cts_n} <= ~lines;
  // Idle mark on the serial input
  assign rx_pin = 1'b1;
endmodule // usr_modem_model

// File: dv/usr_regs_tb_top.sv
// Purpose: Self-checking bench for usr_regs
// Assumes: Bus answer after one wait state, modem lines from the model
// Notes: Level nibbles programmed halt above restore before auto flow
module usr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [2:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n, int_out, rx_serial_out, tx_halt, rx_pin;
  logic tx_serial_in = 1, rx_char_valid = 0, fifo_enable = 0, sleep_enable, loopback_tx;
  logic [7:0] rx_char = 0, xoff2_char = 8'hA5;
  logic [6:0] rx_fifo_level = 0;
  logic [1:0] fifo_setup_in = 2'h2, fifo_setup_bits;
  logic [15:0] baud_divisor;
  logic [3:0] lines = 0, src = 0;
  logic [7:0] rst_v [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  always #10 clk = ~clk;
  usr_regs uut (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
    .cd_n(cd_n), .rts_n(rts_n), .dtr_n(dtr_n), .int_out(int_out),
    .line_err_evt(src[3]), .rx_timeout_evt(src[2]), .rx_data_avail(src[1]),
    .tx_below_level(src[0]), .tx_serial_in(tx_serial_in), .rx_pin(rx_pin),
    .rx_serial_out(rx_serial_out), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .xoff2_char(xoff2_char), .rx_fifo_level(rx_fifo_level), .fifo_enable(fifo_enable),
    .fifo_setup_in(fifo_setup_in), .fifo_setup_bits(fifo_setup_bits), .tx_halt(tx_halt),
    .baud_divisor(baud_divisor), .sleep_enable(sleep_enable), .loopback_tx(loopback_tx));
  usr_modem_model modem (.clk(clk), .lines(lines), .cts_n(cts_n), .dsr_n(dsr_n),
    .ri_n(ri_n), .cd_n(cd_n), .rx_pin(rx_pin));
  task automatic summarize;
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // One bus cycle held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [2:0] a, input logic [7:0] d,
      output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(0, a, d, q);
    @(posedge clk); // Let the write settle before any check
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1, a, 8'h00, q);
    check($sformatf("register %0d", a), q, {24'h0, e});
  endtask
  task automatic lines_to(input logic [3:0] v);
    lines <= v;
    repeat (3) @(posedge clk);
  endtask
  task automatic rx_send(input logic [7:0] c);
    rx_char <= c;
    rx_char_valid <= 1;
    @(posedge clk);
    rx_char_valid <= 0;
  endtask
  task automatic level_chk(input logic [6:0] n, input logic e);
    rx_fifo_level <= n;
    repeat (3) @(posedge clk);
    check("rts_n", rts_n, e);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    logic [31:0] q;
    repeat (3) @(posedge clk);
    reset <= 0;
    foreach (rst_v[i]) rd(i[2:0], rst_v[i]);
    check("divisor", baud_divisor, 32'h1);
    wr(7, 8'hE3);
    rd(7, 8'h03);
    check("dtr_n", dtr_n, 32'h0);
    wr(1, 8'hFF);
    rd(1, 8'h0F);
    wr(3, 8'h10);
    check("setup", fifo_setup_bits, 32'h0);
    wr(3, 8'h10);
    check("setup", fifo_setup_bits, 32'h2);
    wr(1, 8'hF0);
    rd(1, 8'hF0);
    check("sleep_enable", sleep_enable, 32'h1);
    wr(4, 8'h55);
    rd(4, 8'h01);
    wr(1, 8'h00);
    wr(4, 8'h34);
    wr(5, 8'h12);
    check("divisor", baud_divisor, 32'h1234);
    wr(6, 8'h28);
    rd(6, 8'h00);
    wr(7, 8'h40);
    wr(6, 8'h28);
    rd(6, 8'h28);
    // Change flags, ring edge and inverted levels
    lines_to(4'h1);
    rd(0, 8'h11);
    rd(0, 8'h10);
    lines_to(4'h5);
    rd(0, 8'h50);
    lines_to(4'h1);
    rd(0, 8'h14);
    lines_to(4'hB);
    rd(0, 8'hBA);
    lines_to(4'h0);
    rd(0, 8'h0B);
    // Internal loopback
    wr(7, 8'h1F);
    tx_serial_in <= 0;
    bus(1, 0, 8'h00, q);
    rd(0, 8'hF0);
    check("rx_serial_out", rx_serial_out, 32'h0);
    check("loopback_tx", loopback_tx, 32'h1);
    wr(7, 8'h12);
    bus(1, 0, 8'h00, q);
    rd(0, 8'h10);
    wr(7, 8'h00);
    // Priority walk of pending sources
    wr(1, 8'h0F);
    src <= 4'hF;
    rd(2, 8'h06);
    check("int_out", int_out, 32'h1);
    src <= 4'h7;
    rd(2, 8'h0C);
    src <= 4'h3;
    rd(2, 8'h04);
    src <= 4'h1;
    rd(2, 8'h02);
    rd(2, 8'h00);
    rd(0, 8'h01);
    rd(2, 8'h01);
    check("int_out", int_out, 32'h0);
    wr(1, 8'h0D);
    wr(1, 8'h0F);
    fifo_enable <= 1;
    rd(2, 8'hC2);
    src <= 4'h0;
    // Special character detect
    wr(3, 8'h30);
    wr(1, 8'h20);
    rx_send(8'h5A);
    rd(2, 8'hC1);
    rx_send(8'hA5);
    rd(2, 8'hD0);
    rd(2, 8'hC1);
    // Auto clear-to-send and its change interrupt
    wr(3, 8'h90);
    wr(1, 8'h80);
    rd(2, 8'hE0);
    lines_to(4'h1);
    check("tx_halt", tx_halt, 32'h0);
    lines_to(4'h0);
    check("tx_halt", tx_halt, 32'h1);
    rd(2, 8'hE0);
    rd(2, 8'hC1);
    // Auto request-to-send between restore and halt levels
    wr(3, 8'h50);
    level_chk(31, 0);
    level_chk(32, 1);
    level_chk(9, 1);
    level_chk(8, 0);
    summarize();
  end
endmodule // usr_regs_tb_top
